/* File: logic/tsu_top.sv */
// task switch and user vector unit, apb slave with context memory
// assumes software fills gates, descriptors and task blocks first
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tsu_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        external_irq_pin,
  input  wire logic [7:0]  irq_vector,
  input  wire logic        retire_idle,
  output logic             irq_ack,
  output logic             dispatch_valid,
  output logic [7:0]       dispatch_vector,
  output logic [31:0]      saved_ip,
  output logic             err_code_push,
  output logic             switch_done,
  output logic             debug_trap,
  output logic             bad_task_segment_fault
);

  typedef struct packed {
    logic                  rdy;
    logic [31:0]           rdat;
    logic                  serr;
    logic                  pm;
    logic [31:0]           nip;
    logic [31:0]           flg;
    logic [31:0]           ptb;
    logic [15:0]           cur_sel;
    logic [15:0]           cur_lim;
    logic [15:0]           cur_attr;
    logic [8:0]            cur_base;
    logic [15:0]           lts;
    logic [8:0]            madr;
    logic                  go;
    logic [2:0]            kind;
    logic [7:0]            vec;
    logic [15:0]           sel;
    tsu_pkg::tsu_state_type fsm;
    logic [2:0]            step;
    logic                  indir;
    logic [31:0]           tdesc;
    logic [5:0]            err;
    logic                  ack;
    logic                  dval;
    logic [7:0]            dvec;
    logic [31:0]           sip;
    logic                  ecp;
    logic                  done;
    logic                  trap;
    logic                  tsf;
  } tsu_st_type;

  tsu_st_type r;
  tsu_st_type n;

  logic        m_we;
  logic [8:0]  m_addr;
  logic [31:0] m_wd;
  logic [31:0] m_rd;
  logic [7:0]  v_in;
  logic        v_user;
  logic        v_gate;
  logic [15:0] v_sel;

  function automatic logic [8:0] blk_at(input logic [15:0] s, input logic [2:0] w);
    blk_at = tsu_pkg::BLK_BASE + {2'b00, s[6:3], w};
  endfunction

  function automatic logic [8:0] desc_at(input logic [15:0] s);
    desc_at = tsu_pkg::DESC_BASE + {5'b0_0000, s[6:3]};
  endfunction

  function automatic logic is_blk(input logic [3:0] t);
    is_blk = (t == tsu_pkg::T_IDLE) || (t == tsu_pkg::T_BUSY);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= tsu_pkg::A_DISP);
  endfunction

  function automatic logic [2:0] ld_word(input logic [2:0] s);
    case (s)
      3'h0:    ld_word = tsu_pkg::W_PTB;
      3'h1:    ld_word = tsu_pkg::W_NIP;
      3'h2:    ld_word = tsu_pkg::W_FLG;
      3'h3:    ld_word = tsu_pkg::W_LTS;
      default: ld_word = tsu_pkg::W_TRAP;
    endcase
  endfunction

  tsu_mem #(
    .WIDTH (32),
    .DEPTH (tsu_pkg::MEM_DEPTH)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (m_we),
    .addr    (m_addr),
    .wdata   (m_wd),
    .rdata   (m_rd)
  );

  tsu_vec u_vec (
    .vec       (v_in),
    .gate_word (m_rd),
    .is_user   (v_user),
    .is_gate   (v_gate),
    .gate_sel  (v_sel)
  );

  // next state: apb slave, register writes, switch sequencer
  always_comb begin
    logic       wr;
    logic       ext;
    logic       lnk;
    logic [2:0] k;
    logic [5:0] eset;
    logic [5:0] clr;
    wr   = psel & penable & r.rdy & pwrite;
    ext  = 1'b0;
    lnk  = 1'b0;
    k    = r.kind;
    eset = '0;
    clr  = '0;
    n    = r;
    n.ack  = 1'b0;
    n.dval = 1'b0;
    n.done = 1'b0;
    n.trap = 1'b0;
    n.tsf  = 1'b0;
    n.ecp  = 1'b0;
    m_we   = 1'b0;
    m_addr = r.madr;
    m_wd   = pwdata;
    // zero wait: ready in the first access cycle
    n.rdy  = psel & ~penable;
    n.serr = psel & ~penable & ~mapped(paddr);
    n.rdat = '0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        tsu_pkg::A_CTRL: n.rdat = {31'h0, r.pm};
        tsu_pkg::A_CMD:  n.rdat = {r.sel, r.vec, 5'h00, r.kind};
        tsu_pkg::A_STAT: n.rdat = {23'h0, r.go | (r.fsm != tsu_pkg::S_IDLE), 2'b00, r.err};
        tsu_pkg::A_CUR:  n.rdat = {r.cur_lim, r.cur_sel};
        tsu_pkg::A_PTB:  n.rdat = r.ptb;
        tsu_pkg::A_LTS:  n.rdat = {16'h0000, r.lts};
        tsu_pkg::A_NIP:  n.rdat = r.nip;
        tsu_pkg::A_FLG:  n.rdat = r.flg;
        tsu_pkg::A_MADR: n.rdat = {23'h0, r.madr};
        tsu_pkg::A_MDAT: n.rdat = m_rd;
        tsu_pkg::A_DISP: n.rdat = {r.cur_attr, 8'h00, r.dvec};
        default:         n.rdat = '0;
      endcase
    end
    // software writes; live context only while no switch runs
    if (wr) begin
      case (paddr)
        tsu_pkg::A_CTRL: n.pm = pwdata[0];
        tsu_pkg::A_STAT: clr = pwdata[5:0];
        tsu_pkg::A_MADR: n.madr = pwdata[8:0];
        default: ;
      endcase
      if (r.fsm == tsu_pkg::S_IDLE && !r.go) begin
        case (paddr)
          tsu_pkg::A_CMD: begin
            if (pwdata[2:0] <= tsu_pkg::K_SWINT) begin
              n.kind = pwdata[2:0];
              n.vec  = pwdata[15:8];
              n.sel  = pwdata[31:16];
              n.go   = 1'b1;
            end
          end
          tsu_pkg::A_CUR: begin
            n.cur_sel  = pwdata[15:0];
            n.cur_base = blk_at(pwdata[15:0], 3'h0);
            n.cur_lim  = tsu_pkg::BLK_MIN_LIM;
            n.cur_attr = {12'h000, tsu_pkg::T_BUSY};
          end
          tsu_pkg::A_NIP: n.nip = pwdata;
          tsu_pkg::A_FLG: n.flg = pwdata;
          default: ;
        endcase
      end
    end
    // external request waits for retired state and idle sequencer
    ext  = external_irq_pin & r.flg[tsu_pkg::FLG_IF] & retire_idle & ~r.go;
    v_in = (r.fsm == tsu_pkg::S_IDLE) ? (r.go ? r.vec : irq_vector) : r.vec;
    // call and handler dispatch leave a back link; jump and return do not
    lnk  = (r.kind == tsu_pkg::K_CALL) || (r.kind == tsu_pkg::K_SWINT) ||
           (r.kind == tsu_pkg::K_EXT);
    case (r.fsm)
      tsu_pkg::S_IDLE: begin
        if (wr && paddr == tsu_pkg::A_MDAT) begin
          m_we = 1'b1;
        end else if (r.go || ext) begin
          n.go    = 1'b0;
          n.indir = 1'b0;
          n.step  = 3'h0;
          k       = r.go ? r.kind : tsu_pkg::K_EXT;
          if (!r.go) begin
            n.ack  = 1'b1;
            n.kind = tsu_pkg::K_EXT;
            n.vec  = irq_vector;
          end
          case (k)
            tsu_pkg::K_SWINT, tsu_pkg::K_EXT: begin
              if (!v_user) begin
                eset[tsu_pkg::E_VEC] = 1'b1;
              end else begin
                m_addr = tsu_pkg::GATE_BASE + {1'b0, v_in};
                n.fsm  = tsu_pkg::S_GATE;
              end
            end
            tsu_pkg::K_RET: begin
              // plain return without nested flag is the core's business
              if (r.flg[tsu_pkg::FLG_NL]) begin
                if (!r.pm) begin
                  eset[tsu_pkg::E_PM] = 1'b1;
                end else begin
                  m_addr = blk_at(r.cur_sel, tsu_pkg::W_LINK);
                  n.fsm  = tsu_pkg::S_LINK;
                end
              end
            end
            default: begin
              if (!r.pm) begin
                eset[tsu_pkg::E_PM] = 1'b1;
              end else begin
                m_addr = desc_at(r.sel);
                n.fsm  = tsu_pkg::S_DESC;
              end
            end
          endcase
        end
      end
      tsu_pkg::S_GATE: begin
        if (v_gate) begin
          if (!r.pm) begin
            eset[tsu_pkg::E_PM] = 1'b1;
            n.fsm = tsu_pkg::S_IDLE;
          end else begin
            n.sel  = v_sel;
            m_addr = desc_at(v_sel);
            n.fsm  = tsu_pkg::S_DESC;
          end
        end else begin
          // plain delivery: context untouched, resumes after handler
          n.dval = 1'b1;
          n.dvec = r.vec;
          n.sip  = r.nip;
          n.fsm  = tsu_pkg::S_IDLE;
        end
      end
      tsu_pkg::S_LINK: begin
        n.sel  = m_rd[15:0];
        m_addr = desc_at(m_rd[15:0]);
        n.fsm  = tsu_pkg::S_DESC;
      end
      tsu_pkg::S_DESC: begin
        n.fsm = tsu_pkg::S_IDLE;
        if (m_rd[3:0] == tsu_pkg::T_GATE && !r.indir &&
            (r.kind == tsu_pkg::K_CALL || r.kind == tsu_pkg::K_JUMP)) begin
          n.indir = 1'b1;
          n.sel   = m_rd[31:16];
          m_addr  = desc_at(m_rd[31:16]);
          n.fsm   = tsu_pkg::S_DESC;
        end else if (!is_blk(m_rd[3:0]) || m_rd[31:16] < tsu_pkg::BLK_MIN_LIM) begin
          eset[tsu_pkg::E_BLK] = 1'b1;
          n.tsf = 1'b1;
        end else if (r.sel[6:3] == r.cur_sel[6:3]) begin
          eset[tsu_pkg::E_REC] = 1'b1;
        end else if (r.kind != tsu_pkg::K_RET && m_rd[3:0] == tsu_pkg::T_BUSY) begin
          eset[tsu_pkg::E_BSY] = 1'b1;
        end else if (r.kind == tsu_pkg::K_RET && m_rd[3:0] != tsu_pkg::T_BUSY) begin
          eset[tsu_pkg::E_BLK] = 1'b1;
          n.tsf = 1'b1;
        end else begin
          n.tdesc = m_rd;
          n.step  = 3'h0;
          n.fsm   = tsu_pkg::S_SAVE;
        end
      end
      tsu_pkg::S_SAVE: begin
        // outgoing context first; page table base and table register never stored
        m_we   = 1'b1;
        n.step = r.step + 3'h1;
        case (r.step)
          3'h0: begin
            m_addr = blk_at(r.cur_sel, tsu_pkg::W_NIP);
            m_wd   = r.nip;
          end
          3'h1: begin
            m_addr = blk_at(r.cur_sel, tsu_pkg::W_FLG);
            m_wd   = r.flg;
            if (r.kind == tsu_pkg::K_RET) begin
              m_wd[tsu_pkg::FLG_NL] = 1'b0;
            end
          end
          3'h2: begin
            // caller stays busy on call and handler dispatch so it cannot be re-entered; jump and return mark it idle
            m_addr = desc_at(r.cur_sel);
            m_wd   = {r.cur_lim, r.cur_attr[15:4], lnk ? tsu_pkg::T_BUSY : tsu_pkg::T_IDLE};
          end
          3'h3: begin
            m_addr = desc_at(r.sel);
            m_wd   = {r.tdesc[31:4], tsu_pkg::T_BUSY};
          end
          default: begin
            m_we   = lnk;
            m_addr = blk_at(r.sel, tsu_pkg::W_LINK);
            m_wd   = {16'h0000, r.cur_sel};
            n.step = 3'h0;
            n.fsm  = tsu_pkg::S_LOAD;
          end
        endcase
      end
      tsu_pkg::S_LOAD: begin
        // read issued one cycle ahead of its capture
        m_addr = blk_at(r.sel, ld_word(r.step));
        n.step = r.step + 3'h1;
        case (r.step)
          3'h1: n.ptb = m_rd;
          3'h2: n.nip = m_rd;
          3'h3: begin
            n.flg = m_rd;
            if (lnk) begin
              n.flg[tsu_pkg::FLG_NL] = 1'b1;
            end
          end
          3'h4: n.lts = m_rd[15:0];
          3'h5: begin
            if (m_rd[0]) begin
              eset[tsu_pkg::E_TRP] = 1'b1;
              n.trap = 1'b1;
            end
            n.cur_sel  = r.sel;
            n.cur_base = blk_at(r.sel, 3'h0);
            n.cur_lim  = r.tdesc[31:16];
            n.cur_attr = {r.tdesc[15:4], tsu_pkg::T_BUSY};
            n.done     = 1'b1;
            n.fsm      = tsu_pkg::S_IDLE;
          end
          default: ;
        endcase
      end
      default: n.fsm = tsu_pkg::S_IDLE;
    endcase
    // sticky errors: a new event wins over a clear
    n.err = (r.err & ~clr) | eset;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r     <= '0;
      r.fsm <= tsu_pkg::S_IDLE;
    end else begin
      r <= n;
    end
  end

  assign pready                 = r.rdy;
  assign prdata                 = r.rdat;
  assign pslverr                = r.serr;
  assign irq_ack                = r.ack;
  assign dispatch_valid         = r.dval;
  assign dispatch_vector        = r.dvec;
  assign saved_ip               = r.sip;
  assign err_code_push          = r.ecp;
  assign switch_done            = r.done;
  assign debug_trap             = r.trap;
  assign bad_task_segment_fault = r.tsf;

endmodule
`default_nettype wire

/* File: logic/tsu_pkg.sv */
// constants shared by the task switch / user vector unit
// assumes a 512-word context memory holding gates, descriptors and task blocks
package tsu_pkg;

  // apb register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD  = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_CUR  = 8'h0C;
  localparam logic [7:0] A_PTB  = 8'h10;
  localparam logic [7:0] A_LTS  = 8'h14;
  localparam logic [7:0] A_NIP  = 8'h18;
  localparam logic [7:0] A_FLG  = 8'h1C;
  localparam logic [7:0] A_MADR = 8'h20;
  localparam logic [7:0] A_MDAT = 8'h24;
  localparam logic [7:0] A_DISP = 8'h28;

  // request kinds
  localparam logic [2:0] K_CALL  = 3'h0;
  localparam logic [2:0] K_JUMP  = 3'h1;
  localparam logic [2:0] K_RET   = 3'h2;
  localparam logic [2:0] K_SWINT = 3'h3;
  localparam logic [2:0] K_EXT   = 3'h4;

  // descriptor type codes
  localparam logic [3:0] T_IDLE = 4'h9;
  localparam logic [3:0] T_BUSY = 4'hB;
  localparam logic [3:0] T_GATE = 4'h5;

  localparam logic [15:0] BLK_MIN_LIM  = 16'h0067;
  localparam logic [7:0]  USER_VEC_MIN = 8'h20;

  // context memory layout
  localparam int         MEM_AW    = 9;
  localparam int         MEM_DEPTH = 512;
  localparam logic [8:0] GATE_BASE = 9'h000;
  localparam logic [8:0] DESC_BASE = 9'h100;
  localparam logic [8:0] BLK_BASE  = 9'h180;

  // word positions inside one task block
  localparam logic [2:0] W_LINK = 3'h0;
  localparam logic [2:0] W_PTB  = 3'h1;
  localparam logic [2:0] W_NIP  = 3'h2;
  localparam logic [2:0] W_FLG  = 3'h3;
  localparam logic [2:0] W_LTS  = 3'h4;
  localparam logic [2:0] W_TRAP = 3'h5;

  // flag word bits and sticky error bits
  localparam int FLG_IF = 9;
  localparam int FLG_NL = 14;
  localparam int E_VEC  = 0;
  localparam int E_PM   = 1;
  localparam int E_REC  = 2;
  localparam int E_BSY  = 3;
  localparam int E_BLK  = 4;
  localparam int E_TRP  = 5;

  typedef enum logic [5:0] {
    S_IDLE = 6'b00_0001,
    S_GATE = 6'b00_0010,
    S_LINK = 6'b00_0100,
    S_DESC = 6'b00_1000,
    S_SAVE = 6'b01_0000,
    S_LOAD = 6'b10_0000
  } tsu_state_type;

endpackage

/* File: logic/tsu_mem.sv */
// single port context memory with registered read data
// assumes one access per cycle; read returns the old word on a write
`timescale 1ns/10ps
`default_nettype none
module tsu_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 512
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [WIDTH-1:0]         wdata,
  output logic      [WIDTH-1:0]         rdata
);

  // refuse sizes the address math cannot serve
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("tsu_mem: bad size");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // array has no reset; software must fill it before use
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read register, read-first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule
`default_nettype wire

/* File: logic/tsu_vec.sv */
// vector classifier: user range check and gate entry decode
// assumes gate words carry type in [3:0] and selector in [31:16]
`timescale 1ns/10ps
`default_nettype none
module tsu_vec (
  input  wire logic [7:0]  vec,
  input  wire logic [31:0] gate_word,
  output logic             is_user,
  output logic             is_gate,
  output logic [15:0]      gate_sel
);

  // vectors 32..255 are user defined
  always_comb begin
    is_user  = (vec >= tsu_pkg::USER_VEC_MIN);
    is_gate  = (gate_word[3:0] == tsu_pkg::T_GATE);
    gate_sel = gate_word[31:16];
  end

endmodule
`default_nettype wire

/* File: bench/tsu_irq_src.sv */
// behavioural external interrupt requester
// assumes one request at a time, held as a level until acknowledged
`timescale 1ns/10ps
`default_nettype none
module tsu_irq_src (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       req,
  input  wire logic [7:0] req_vec,
  input  wire logic       irq_ack,
  output logic            pin,
  output logic [7:0]      vec
);
  // level request with vector; released vector shows its inverse, not stale data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b0;
      vec <= 8'h00;
    end else if (pin && irq_ack) begin
      pin <= 1'b0;
      vec <= ~vec;
    end else if (req && !pin) begin
      pin <= 1'b1;
      vec <= req_vec;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tsu_top_assertions.sv */
// port assertions for the task switch and user vector unit
// assumes binding into tsu_top, single pclk domain
`timescale 1ns/10ps
`default_nettype none
module tsu_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       external_irq_pin,
  input wire logic       retire_idle,
  input wire logic       irq_ack,
  input wire logic       dispatch_valid,
  input wire logic [7:0] dispatch_vector,
  input wire logic       err_code_push,
  input wire logic       switch_done,
  input wire logic       debug_trap,
  input wire logic       bad_task_segment_fault
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb side: zero wait slave, error only with the answer
  property p_ready; psel && !penable |=> pready; endproperty
  property p_slverr; pslverr |-> pready; endproperty
  // interrupt take needs a request and retired older instructions
  property p_take; irq_ack |-> $past(external_irq_pin && retire_idle); endproperty
  property p_ack; irq_ack |=> !irq_ack; endproperty
  property p_user; dispatch_valid |-> dispatch_vector >= 8'h20; endproperty
  property p_noerr; !err_code_push; endproperty
  // switch outcome pulses; a fault never completes a switch
  property p_trap; debug_trap |-> switch_done; endproperty
  property p_done; switch_done |=> !switch_done [*3]; endproperty
  property p_fault; bad_task_segment_fault |-> !switch_done; endproperty

  a_ready: assert property (p_ready) else $error("pready missing after setup");
  a_slverr: assert property (p_slverr) else $error("pslverr without pready");
  a_take: assert property (p_take) else $error("irq taken without cause");
  a_ack: assert property (p_ack) else $error("irq ack longer than one cycle");
  a_user: assert property (p_user) else $error("dispatch of non user vector");
  a_noerr: assert property (p_noerr) else $error("error code pushed");
  a_trap: assert property (p_trap) else $error("trap without switch");
  a_done: assert property (p_done) else $error("switch done not a pulse");
  a_fault: assert property (p_fault) else $error("fault with switch done");

  c_ext: cover property (irq_ack ##1 dispatch_valid);
  c_trap: cover property (debug_trap);
  c_fault: cover property (bad_task_segment_fault);
endmodule

bind tsu_top tsu_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .external_irq_pin(external_irq_pin), .retire_idle(retire_idle),
  .irq_ack(irq_ack), .dispatch_valid(dispatch_valid), .dispatch_vector(dispatch_vector),
  .err_code_push(err_code_push), .switch_done(switch_done), .debug_trap(debug_trap),
  .bad_task_segment_fault(bad_task_segment_fault)
);
`default_nettype wire

/* File: bench/testbench.sv */
// scenario bench for the task switch and user vector unit
// assumes package, design, requester and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        pin, req, retire_idle, irq_ack, dispatch_valid, done, trap, fault;
  logic [7:0]  paddr, vec, req_vec, dispatch_vector;
  logic [31:0] pwdata, prdata, rv, saved_ip;
  int          n_fail, cmp_count;

  tsu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .external_irq_pin(pin), .irq_vector(vec), .retire_idle(retire_idle),
    .irq_ack(irq_ack), .dispatch_valid(dispatch_valid), .dispatch_vector(dispatch_vector),
    .saved_ip(saved_ip), .err_code_push(), .switch_done(done), .debug_trap(trap),
    .bad_task_segment_fault(fault));
  tsu_irq_src u_src (.pclk(pclk), .presetn(presetn), .req(req), .req_vec(req_vec),
    .irq_ack(irq_ack), .pin(pin), .vec(vec));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // verdict and comparison helpers
  task automatic stop_test;
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tmo(input string n);
    n_fail++;
    $display("mismatch %s expected event seen timeout", n);
    stop_test();
  endtask

  // apb master: holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 9; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) tmo("pready");
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string n);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rv & m);
  endtask
  task automatic mw(input logic [8:0] a, input logic [31:0] d);
    wr(tsu_pkg::A_MADR, {23'h00_0000, a});
    wr(tsu_pkg::A_MDAT, d);
  endtask
  task automatic mr(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string n);
    wr(tsu_pkg::A_MADR, {23'h00_0000, a});
    rc(tsu_pkg::A_MDAT, m, e, n);
  endtask
  // status polling bounded by read count, not by assumed latency
  task automatic poll(input logic [31:0] m);
    int i;
    for (i = 0; i < 30; i++) begin
      apb(1'b0, tsu_pkg::A_STAT, 32'h0000_0000);
      if ((rv & m) === m) begin
        cmp_count++;
        wr(tsu_pkg::A_STAT, 32'h0000_003F);
        return;
      end
    end
    tmo("status");
  endtask
  // wait for an output pulse: 0 done, 1 dispatch, 2 fault, 3 ack
  task automatic wt(input int s);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge pclk);
      if ((s == 0 && done === 1'b1) || (s == 1 && dispatch_valid === 1'b1) ||
          (s == 2 && fault === 1'b1) || (s == 3 && irq_ack === 1'b1)) begin
        cmp_count++;
        return;
      end
    end
    tmo("pulse");
  endtask
  task automatic cmd(input logic [15:0] sel, input logic [7:0] v, input logic [2:0] k);
    wr(tsu_pkg::A_CMD, {sel, v, 5'h00, k});
  endtask
  function automatic logic [31:0] fp(input logic [3:0] x);
    return {4'h0, x, 24'h00_1000};
  endfunction
  function automatic logic [31:0] fn(input logic [3:0] x);
    return {20'h0_0000, x, 8'h40};
  endfunction
  // task block and descriptor for index x
  task automatic mk(input logic [3:0] x, input logic [15:0] lim, input logic [3:0] t,
                    input logic [31:0] trp);
    logic [8:0] b;
    b = tsu_pkg::BLK_BASE + {2'b00, x, 3'b000};
    mw(tsu_pkg::DESC_BASE + {5'h00, x}, {lim, 12'h000, t});
    mw(b, 32'h0000_0000);
    mw(b + 9'h001, fp(x));
    mw(b + 9'h002, fn(x));
    mw(b + 9'h003, 32'h0000_0000);
    mw(b + 9'h004, {24'h00_0000, x, 4'h4});
    mw(b + 9'h005, trp);
  endtask

  // reset values and an unmapped address
  task automatic t_reset;
    rc(tsu_pkg::A_STAT, 32'hFFFF_FFFF, 32'h0000_0000, "stat");
    rc(tsu_pkg::A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl");
    rc(8'h2C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    chk("slverr", 32'h0000_0001, {31'h0, er});
  endtask
  // call outside protected mode is refused, holder unchanged
  task automatic t_pm;
    cmd(16'h0010, 8'h00, tsu_pkg::K_CALL);
    poll(32'h0000_0002);
    rc(tsu_pkg::A_CUR, 32'h0000_FFFF, 32'h0000_0000, "cur");
  endtask
  // software vectors at both range ends, and one below it
  task automatic t_swint;
    logic [7:0] v[3];
    int i;
    v = '{8'h20, 8'h40, 8'hFF};
    wr(tsu_pkg::A_CTRL, 32'h0000_0001);
    wr(tsu_pkg::A_NIP, 32'h0000_1234);
    for (i = 0; i < 3; i++) begin
      mw({1'b0, v[i]}, 32'h0000_0000);
      cmd(16'h0000, v[i], tsu_pkg::K_SWINT);
      wt(1);
      chk("vector", {24'h00_0000, v[i]}, {24'h00_0000, dispatch_vector});
      chk("saved ip", 32'h0000_1234, saved_ip);
    end
    rc(tsu_pkg::A_NIP, 32'hFFFF_FFFF, 32'h0000_1234, "nip kept");
    cmd(16'h0000, 8'h1F, tsu_pkg::K_SWINT);
    poll(32'h0000_0001);
  endtask
  // call, self call, return through the back link
  task automatic t_call;
    mk(4'h1, 16'h0067, tsu_pkg::T_BUSY, 32'h0000_0000);
    mk(4'h2, 16'h0067, tsu_pkg::T_IDLE, 32'h0000_0000);
    wr(tsu_pkg::A_CUR, 32'h0000_0008);
    wr(tsu_pkg::A_NIP, 32'h0000_00A0);
    wr(tsu_pkg::A_FLG, 32'h0000_0000);
    mw(9'h106, 32'h0010_0005);
    cmd(16'h0030, 8'h00, tsu_pkg::K_CALL);
    wt(0);
    rc(tsu_pkg::A_CUR, 32'hFFFF_FFFF, 32'h0067_0010, "cur");
    rc(tsu_pkg::A_PTB, 32'hFFFF_FFFF, fp(4'h2), "ptb");
    rc(tsu_pkg::A_NIP, 32'hFFFF_FFFF, fn(4'h2), "nip");
    rc(tsu_pkg::A_LTS, 32'h0000_FFFF, 32'h0000_0024, "table sel");
    rc(tsu_pkg::A_FLG, 32'h0000_4000, 32'h0000_4000, "nested");
    mr(9'h190, 32'h0000_FFFF, 32'h0000_0008, "link");
    mr(9'h18A, 32'hFFFF_FFFF, 32'h0000_00A0, "saved nip");
    mr(9'h102, 32'h0000_000F, 32'h0000_000B, "busy");
    cmd(16'h0010, 8'h00, tsu_pkg::K_CALL);
    poll(32'h0000_0004);
    cmd(16'h0000, 8'h00, tsu_pkg::K_RET);
    wt(0);
    rc(tsu_pkg::A_CUR, 32'h0000_FFFF, 32'h0000_0008, "back");
    rc(tsu_pkg::A_NIP, 32'hFFFF_FFFF, 32'h0000_00A0, "resume");
    mr(9'h102, 32'h0000_000F, 32'h0000_0009, "idle");
  endtask
  // short limit faults; trap bit gives a debug pulse with the switch
  task automatic t_fault;
    mk(4'h3, 16'h0060, tsu_pkg::T_IDLE, 32'h0000_0000);
    cmd(16'h0018, 8'h00, tsu_pkg::K_JUMP);
    wt(2);
    poll(32'h0000_0010);
    mk(4'h4, 16'h0067, tsu_pkg::T_IDLE, 32'h0000_0001);
    cmd(16'h0020, 8'h00, tsu_pkg::K_JUMP);
    wt(0);
    chk("trap", 32'h0000_0001, {31'h0, trap});
    poll(32'h0000_0020);
    mw(9'h060, 32'h0010_0005);
    cmd(16'h0000, 8'h60, tsu_pkg::K_SWINT);
    wt(0);
    rc(tsu_pkg::A_CUR, 32'h0000_FFFF, 32'h0000_0010, "handler");
  endtask
  // external request waits for retirement, then dispatches
  task automatic t_ext;
    logic seen;
    int i;
    seen = 1'b0;
    mw(9'h050, 32'h0000_0000);
    wr(tsu_pkg::A_FLG, 32'h0000_0200);
    req <= 1'b1;
    req_vec <= 8'h50;
    @(posedge pclk);
    req <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      seen = seen | (irq_ack === 1'b1);
    end
    chk("early ack", 32'h0000_0000, {31'h0, seen});
    retire_idle <= 1'b1;
    wt(3);
    wt(1);
    chk("ext vector", 32'h0000_0050, {24'h00_0000, dispatch_vector});
    chk("ext ip", fn(4'h2), saved_ip);
  endtask

  // reset, then the scenarios in order
  initial begin
    n_fail = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    req = 1'b0;
    req_vec = 8'h00;
    retire_idle = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_pm();
    t_swint();
    t_call();
    t_fault();
    t_ext();
    stop_test();
  end
endmodule
`default_nettype wire
